// >>> sdio_consts.svh
// Object indices, field positions, reset values and masks for the servo digital I/O objects
`ifndef SDIO_CONSTS_SVH
`define SDIO_CONSTS_SVH
`define SDIO_IDX_INPUT 16'h60fd
`define SDIO_IDX_OUTPUT 16'h60fe
`define SDIO_SUB_COUNT 8'h00
`define SDIO_SUB_PHYS 8'h01
`define SDIO_SUB_MASK 8'h02
`define SDIO_ENTRY_COUNT 8'h02
`define SDIO_BIT_REV_LIMIT 0
`define SDIO_BIT_FWD_LIMIT 1
`define SDIO_BIT_ORIGIN 2
`define SDIO_BIT_RETURN 18
`define SDIO_BIT_MON_LO 19
`define SDIO_BIT_POS_DONE 24
`define SDIO_BIT_RETURN_STATUS 25
`define SDIO_BIT_BRAKE 0
`define SDIO_BIT_GEN_OUT 16
`define SDIO_IN_VALID 32'h01f80007
`define SDIO_OUT_VALID 32'h00010001
`define SDIO_PHYS_RESET 32'h00000000
`define SDIO_MASK_RESET 32'h00000000
`define SDIO_SYNC_W 9
`endif

// >>> sdio_pkg.sv
// Types shared by the servo digital I/O object block
package sdio_pkg;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] wdata;
   } sdio_req_t;
   typedef struct packed {
      logic [31:0] rdata;
      logic ack;
      logic err;
   } sdio_rsp_t;
   typedef struct packed {
      logic [4:0] safety_monitor;
      logic positioning_complete;
      logic origin_input;
      logic forward_limit_input;
      logic reverse_limit_input;
   } sdio_pins_t;
   typedef struct packed {
      logic [31:0] phys;
      logic [31:0] mask;
      logic [31:0] rdata;
      logic ack;
      logic err;
      logic brake;
      logic gen_out;
   } sdio_state_t;
   typedef struct packed {
      logic [8:0] s1;
      logic [8:0] s2;
   } sdio_sync_state_t;
endpackage : sdio_pkg

// >>> sdio_sync.sv
// Two-flop synchroniser for the external input pins
`timescale 1ns/100ps
`include "sdio_consts.svh"
module sdio_sync (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Pins in, synchronised levels out
   input wire logic [`SDIO_SYNC_W-1:0] i_async,
   output logic [`SDIO_SYNC_W-1:0] o_sync
);
   sdio_pkg::sdio_sync_state_t st_r;
   sdio_pkg::sdio_sync_state_t st_nxt;
   genvar g;
   // One two-stage chain per bit
   generate
      for (g = 0; g < `SDIO_SYNC_W; g++) begin : g_bit
         always_comb begin
            st_nxt.s1[g] = i_async[g];
            st_nxt.s2[g] = st_r.s1[g];
         end
      end
   endgenerate
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_sync = st_r.s2;
endmodule : sdio_sync

// >>> sdio_objects.sv
// Digital input and output objects of the servo drive, reached by index and sub-index
`timescale 1ns/100ps
`include "sdio_consts.svh"
module sdio_objects (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Object access port
   input wire sdio_pkg::sdio_req_t i_req,
   output sdio_pkg::sdio_rsp_t o_rsp,
   // Communication state, high while process data runs
   input wire logic i_comm_ok,
   // External input pins
   input wire sdio_pkg::sdio_pins_t i_pins,
   // External outputs
   output logic o_brake_set,
   output logic o_gen_out
);
   sdio_pkg::sdio_state_t st_r;
   sdio_pkg::sdio_state_t st_nxt;
   sdio_pkg::sdio_pins_t pins_s;
   logic [31:0] in_word;
   logic hit_in;
   logic hit_cnt;
   logic hit_phys;
   logic hit_mask;
   logic req_any;

   sdio_sync u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async(i_pins),
      .o_sync(pins_s)
   );

   // Input status word
   always_comb begin
      in_word = 32'h00000000;
      in_word[`SDIO_BIT_REV_LIMIT] = pins_s.reverse_limit_input;
      in_word[`SDIO_BIT_FWD_LIMIT] = pins_s.forward_limit_input;
      in_word[`SDIO_BIT_ORIGIN] = pins_s.origin_input;
      in_word[`SDIO_BIT_MON_LO +: 5] = pins_s.safety_monitor;
      in_word[`SDIO_BIT_POS_DONE] = pins_s.positioning_complete;
      in_word[`SDIO_BIT_RETURN] = 1'b0;
      in_word[`SDIO_BIT_RETURN_STATUS] = 1'b0;
   end

   // Address decode
   always_comb begin
      req_any = i_req.rd | i_req.wr;
      hit_in = 1'b0;
      hit_cnt = 1'b0;
      hit_phys = 1'b0;
      hit_mask = 1'b0;
      if (i_req.index == `SDIO_IDX_INPUT && i_req.sub == `SDIO_SUB_COUNT) begin
         hit_in = 1'b1;
      end else if (i_req.index == `SDIO_IDX_OUTPUT && i_req.sub == `SDIO_SUB_COUNT) begin
         hit_cnt = 1'b1;
      end else if (i_req.index == `SDIO_IDX_OUTPUT && i_req.sub == `SDIO_SUB_PHYS) begin
         hit_phys = 1'b1;
      end else if (i_req.index == `SDIO_IDX_OUTPUT && i_req.sub == `SDIO_SUB_MASK) begin
         hit_mask = 1'b1;
      end
   end

   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = req_any;
      st_nxt.err = 1'b0;
      st_nxt.rdata = 32'h00000000;
      if (i_req.wr) begin
         if (hit_phys) begin
            st_nxt.phys = i_req.wdata & `SDIO_OUT_VALID;
         end else if (hit_mask) begin
            st_nxt.mask = i_req.wdata & `SDIO_OUT_VALID;
         end else begin
            st_nxt.err = 1'b1;
         end
      end else if (i_req.rd) begin
         if (hit_in) begin
            st_nxt.rdata = in_word;
         end else if (hit_cnt) begin
            st_nxt.rdata = {24'h000000, `SDIO_ENTRY_COUNT};
         end else if (hit_phys) begin
            st_nxt.rdata = st_r.phys;
         end else if (hit_mask) begin
            st_nxt.rdata = st_r.mask;
         end else begin
            st_nxt.err = 1'b1;
         end
      end
      // Brake applied unless link up and bit enabled, then follows command
      st_nxt.brake = ~(i_comm_ok & st_r.mask[`SDIO_BIT_BRAKE]) | st_r.phys[`SDIO_BIT_BRAKE];
      // General output: zero when masked, holds while link is down
      if (!st_r.mask[`SDIO_BIT_GEN_OUT]) begin
         st_nxt.gen_out = 1'b0;
      end else if (i_comm_ok) begin
         st_nxt.gen_out = st_r.phys[`SDIO_BIT_GEN_OUT];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '{phys: `SDIO_PHYS_RESET, mask: `SDIO_MASK_RESET, rdata: 32'h00000000,
                   ack: 1'b0, err: 1'b0, brake: 1'b1, gen_out: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rsp.rdata = st_r.rdata;
   assign o_rsp.ack = st_r.ack;
   assign o_rsp.err = st_r.err;
   assign o_brake_set = st_r.brake;
   assign o_gen_out = st_r.gen_out;

   // Checks
   a_input_origin_path: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && hit_in) |=> o_rsp.rdata[2] == $past(i_pins.origin_input, 3))
      else $error("origin bit does not follow pin");
   a_input_rev_path: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && hit_in) |=> o_rsp.rdata[0] == $past(i_pins.reverse_limit_input, 3))
      else $error("reverse limit bit does not follow pin");
   a_pos_done_bit: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && hit_in) |=> o_rsp.rdata[24] == $past(i_pins.positioning_complete, 3))
      else $error("positioning complete bit wrong");
   a_input_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && hit_in) |=> (o_rsp.rdata & ~`SDIO_IN_VALID) == 32'h00000000)
      else $error("reserved input bits not zero");
   a_monitor_bits: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && hit_in) |=> o_rsp.rdata[23:19] == $past(i_pins.safety_monitor, 3))
      else $error("safety monitor bits wrong");
   a_mask_readback: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.wr && hit_mask) ##1 (i_req.rd && hit_mask && !i_req.wr)
      |=> o_rsp.rdata == ($past(i_req.wdata, 2) & `SDIO_OUT_VALID))
      else $error("mask read back differs from write");
   a_phys_unused_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && (hit_phys || hit_mask)) |=> (o_rsp.rdata & ~`SDIO_OUT_VALID) == 32'h00000000)
      else $error("unused output bits not zero");
   a_gen_out_masked: assert property (@(posedge i_clk) disable iff (i_rst)
      !st_r.mask[16] |=> !o_gen_out)
      else $error("masked general output not zero");
   a_brake_masked: assert property (@(posedge i_clk) disable iff (i_rst)
      (!st_r.mask[0] || !i_comm_ok) |=> o_brake_set)
      else $error("brake released without enable");
   a_unmapped_err: assert property (@(posedge i_clk) disable iff (i_rst)
      (req_any && !(hit_in || hit_cnt || hit_phys || hit_mask)) |=> o_rsp.ack && o_rsp.err)
      else $error("unmapped access not flagged");
   c_read_input: cover property (@(posedge i_clk) disable iff (i_rst) i_req.rd && hit_in);
   c_write_phys: cover property (@(posedge i_clk) disable iff (i_rst) i_req.wr && hit_phys);
   c_gen_out_on: cover property (@(posedge i_clk) disable iff (i_rst) o_gen_out);
   c_brake_off: cover property (@(posedge i_clk) disable iff (i_rst) !o_brake_set);
endmodule : sdio_objects

// >>> sdio_master_model.sv
// Fieldbus master model driving the object access port
`timescale 1ns/100ps
module sdio_master_model (
   // Clock
   input wire logic i_clk,
   // Requests and link state
   output sdio_pkg::sdio_req_t o_req,
   output logic o_comm_ok
);
   // Brake command and release taken as routed to physical outputs
   initial begin
      o_req = '0;
      o_comm_ok = 1'b0;
   end
   // One request, held over its taking edge, then address and data scrambled
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd);
      @(negedge i_clk);
      o_req = {~wr, wr, idx, sub, wd};
      @(negedge i_clk);
      o_req = {2'b00, ~o_req[55:0]};
   endtask : xfer
   // Write then read the same entry on back-to-back edges
   task automatic wr_rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
      @(negedge i_clk);
      o_req = {1'b0, 1'b1, idx, sub, wd};
      @(negedge i_clk);
      o_req = {1'b1, 1'b0, idx, sub, ~wd};
      @(negedge i_clk);
      o_req = {2'b00, ~o_req[55:0]};
   endtask : wr_rd
   // Output object is written whatever the link state; only brake and general output follow it
   task automatic link(input logic up);
      @(negedge i_clk);
      o_comm_ok = up;
   endtask : link
endmodule : sdio_master_model

// >>> servo_digital_io_objects_bench.sv
// Self-checking bench for the servo digital I/O objects
`timescale 1ns/100ps
`include "sdio_consts.svh"
module servo_digital_io_objects_bench;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   sdio_pkg::sdio_req_t req;
   sdio_pkg::sdio_rsp_t rsp;
   logic comm_ok;
   logic [8:0] pins = 9'h000;
   logic o_brake_set;
   logic o_gen_out;
   logic [32:0] exp_q[$];
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] ph;
   logic [31:0] mk;
   logic gen;
   always #20 i_clk = ~i_clk;
   sdio_master_model u_master (.i_clk(i_clk), .o_req(req), .o_comm_ok(comm_ok));
   sdio_objects u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rsp(rsp),
      .i_comm_ok(comm_ok), .i_pins(pins), .o_brake_set(o_brake_set), .o_gen_out(o_gen_out));
   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] ex);
      tests_run++;
      if (seen !== ex) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, input logic [32:0] ex);
      exp_q.push_back(ex);
      u_master.xfer(wr, idx, sub, wd);
   endtask : acc
   always @(negedge i_clk) begin
      if (rsp.ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("spare ack", 33'h1, 33'h0);
         end else begin
            check("response", {rsp.err, rsp.rdata}, exp_q.pop_front());
         end
      end
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      ph = $urandom(32'h84a8);
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
      check("brake reset", {32'h0, o_brake_set}, 33'h1);
      check("gen reset", {32'h0, o_gen_out}, 33'h0);
      acc(1'b0, 16'h60fe, 8'h00, 32'h0, 33'h2);
      acc(1'b0, 16'h60fe, 8'h01, 32'h0, 33'h0);
      acc(1'b0, 16'h60fe, 8'h02, 32'h0, 33'h0);
      acc(1'b1, 16'h60fd, 8'h00, 32'hffffffff, {1'b1, 32'h0});
      acc(1'b1, 16'h60fe, 8'h00, 32'h5, {1'b1, 32'h0});
      acc(1'b0, 16'h60fe, 8'h03, 32'h0, {1'b1, 32'h0});
      acc(1'b0, 16'h1234, 8'h00, 32'h0, {1'b1, 32'h0});
      u_master.link(1'b1);
      repeat (10) begin
         pins = 9'($urandom);
         ph = $urandom;
         mk = $urandom;
         acc(1'b1, 16'h60fe, 8'h01, ph, 33'h0);
         acc(1'b1, 16'h60fe, 8'h02, mk, 33'h0);
         acc(1'b0, 16'h60fe, 8'h01, 32'h0, {1'b0, ph & `SDIO_OUT_VALID});
         acc(1'b0, 16'h60fe, 8'h02, 32'h0, {1'b0, mk & `SDIO_OUT_VALID});
         exp_q.push_back(33'h0);
         exp_q.push_back({1'b0, mk & `SDIO_OUT_VALID});
         u_master.wr_rd(16'h60fe, 8'h02, mk);
         acc(1'b0, 16'h60fd, 8'h00, 32'h0,
             {8'h00, pins[3], pins[8:4], 16'h0000, pins[2:0]});
         gen = mk[16] & ph[16];
         repeat (3) @(negedge i_clk);
         check("brake", {32'h0, o_brake_set}, {32'h0, ~mk[0] | ph[0]});
         check("gen out", {32'h0, o_gen_out}, {32'h0, gen});
      end
      u_master.link(1'b0);
      repeat (3) @(negedge i_clk);
      check("brake link down", {32'h0, o_brake_set}, 33'h1);
      check("gen hold", {32'h0, o_gen_out}, {32'h0, gen});
      check("queue empty", 33'(exp_q.size()), 33'h0);
      complete_run();
   end
endmodule : servo_digital_io_objects_bench
